//--- hdl/tbd_top.sv
`include "tbd_map.svh"
`default_nettype none
// Contract
// - periodic time base with own interrupt
// - enable bit gates tick generation
// - fast source tick taps 2^23 to 2^9
// - slow source taps; low speed only 000/001
// - irq on every falling edge of tap
// - enabling never clears the divider chain
// - rate and enable may be written together
// - divider output near 50% duty square wave
// - output enable bit gates the pin
// - output taps 2^13..2^10 or 2^5..2^2
module tbd_top
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic [`TBD_FAST_W-1:0] fast_div_i,
    input  wire logic [`TBD_SLOW_W-1:0] slow_div_i,
    input  wire logic                   low_speed_mode_i,
    output logic                        timebase_irq_o,
    output logic                        divider_out_pin_n_o
);
    tbd_tap_if tap ();

    // chain taps and mode come from other clocks: two flops first
    logic [`TBD_FAST_W-1:0] fast_s1_ff, fast_s2_ff;
    logic [`TBD_SLOW_W-1:0] slow_s1_ff, slow_s2_ff;
    logic                   mode_s1_ff, mode_s2_ff;

    always_ff @(posedge clk_i)
    begin
        fast_s1_ff   <= fast_div_i;
        fast_s2_ff   <= fast_s1_ff;
        slow_s1_ff   <= slow_div_i;
        slow_s2_ff   <= slow_s1_ff;
        mode_s1_ff   <= low_speed_mode_i;
        mode_s2_ff   <= mode_s1_ff;
    end

    logic [7:0] ctrl_ff, nxt_ctrl;
    logic       src_ff, nxt_src;
    logic       tick_prev_ff, nxt_tick_prev;
    logic       irq_ff, nxt_irq;
    logic       dvo_n_ff, nxt_dvo_n;
    logic       ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    tbd_pkg::tbd_bus_state_t bus_ff, nxt_bus;
    logic       tick_fall;

    assign tap.fast_div  = fast_s2_ff;
    assign tap.slow_div  = slow_s2_ff;
    assign tap.src_sel   = src_ff;
    assign tap.slow_mode = mode_s2_ff;
    assign tap.tick_code = ctrl_ff[`TBD_TICK_RATE_HI:`TBD_TICK_RATE_LO];
    assign tap.dvo_code  = ctrl_ff[`TBD_DVO_RATE_HI:`TBD_DVO_RATE_LO];

    tbd_tap_sel u_sel
    (
        .tap (tap.sel)
    );

    // address decode shared by read and write paths
    function automatic logic [1:0] reg_hit(input logic [7:0] adr);
        logic [1:0] h;
        h = 2'h3;
        if (adr == `TBD_CTRL_OFS)
            h = 2'h0;
        else if (adr == `TBD_CFG_OFS)
            h = 2'h1;
        else if (adr == `TBD_STAT_OFS)
            h = 2'h2;
        return h;
    endfunction

    // bus slave plus timer next state
    always_comb
    begin
        nxt_ctrl      = ctrl_ff;
        nxt_src       = src_ff;
        nxt_bus       = bus_ff;
        nxt_ack       = 1'b0;
        nxt_rdat      = rdat_ff;
        // previous level tracked always, so enabling cannot fake an edge
        nxt_tick_prev = tap.tick_lvl;
        tick_fall     = tick_prev_ff & ~tap.tick_lvl;
        nxt_irq       = tick_fall & ctrl_ff[`TBD_TB_EN_BIT] & tap.tick_ok;
        // pin idles high, else follows the tap inverted for active low
        nxt_dvo_n     = ctrl_ff[`TBD_DVO_EN_BIT] ? ~tap.dvo_lvl : 1'b1;
        case (bus_ff)
            tbd_pkg::TBD_BUS_IDLE:
            begin
                if (wb_cyc_i && wb_stb_i)
                begin
                    nxt_ack  = 1'b1;
                    nxt_bus  = tbd_pkg::TBD_BUS_ACK;
                    nxt_rdat = 32'h0000_0000;
                    case (reg_hit(wb_adr_i))
                        2'h0:    nxt_rdat[7:0] = ctrl_ff;
                        2'h1:    nxt_rdat[`TBD_SRC_SEL_BIT] = src_ff;
                        2'h2:
                        begin
                            nxt_rdat[`TBD_STAT_TICK_BIT] = tap.tick_lvl;
                            nxt_rdat[`TBD_STAT_DVO_BIT]  = dvo_n_ff;
                            nxt_rdat[`TBD_STAT_SLOW_BIT] = mode_s2_ff;
                            nxt_rdat[`TBD_STAT_SRC_BIT]  = src_ff;
                        end
                        default: nxt_rdat = 32'h0000_0000;
                    endcase
                end
            end
            tbd_pkg::TBD_BUS_ACK:
            begin
                // write lands on the edge the master sees ack
                nxt_bus = tbd_pkg::TBD_BUS_IDLE;
                if (wb_we_i && wb_sel_i[0])
                begin
                    case (reg_hit(wb_adr_i))
                        2'h0:    nxt_ctrl = wb_dat_i[7:0] & `TBD_CTRL_WMASK;
                        2'h1:    nxt_src  = wb_dat_i[`TBD_SRC_SEL_BIT];
                        default: nxt_ctrl = ctrl_ff;
                    endcase
                end
            end
            default: nxt_bus = tbd_pkg::TBD_BUS_IDLE;
        endcase
    end

    // register everything
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff      <= `TBD_CTRL_RESET;
            src_ff       <= `TBD_CFG_RESET;
            tick_prev_ff <= 1'b0;
            irq_ff       <= 1'b0;
            dvo_n_ff     <= 1'b1;
            ack_ff       <= 1'b0;
            rdat_ff      <= 32'h0000_0000;
            bus_ff       <= tbd_pkg::TBD_BUS_IDLE;
        end
        else
        begin
            ctrl_ff      <= nxt_ctrl;
            src_ff       <= nxt_src;
            tick_prev_ff <= nxt_tick_prev;
            irq_ff       <= nxt_irq;
            dvo_n_ff     <= nxt_dvo_n;
            ack_ff       <= nxt_ack;
            rdat_ff      <= nxt_rdat;
            bus_ff       <= nxt_bus;
        end
    end

    assign wb_ack_o            = ack_ff;
    assign wb_dat_o            = rdat_ff;
    assign timebase_irq_o      = irq_ff;
    assign divider_out_pin_n_o = dvo_n_ff;

    chk_irq_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        timebase_irq_o |=> !timebase_irq_o)
        else $error("tick irq longer than one cycle");

    chk_irq_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(ctrl_ff[`TBD_TB_EN_BIT]) |-> !timebase_irq_o)
        else $error("tick irq while disabled");

    chk_irq_on_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ctrl_ff[`TBD_TB_EN_BIT] && tap.tick_ok && tick_prev_ff && !tap.tick_lvl) |-> timebase_irq_o)
        else $error("falling tap edge without irq");

    chk_fast_tick_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (!src_ff && !mode_s2_ff && ctrl_ff[2:0] == 3'h3) |-> tap.tick_lvl == fast_s2_ff[14])
        else $error("fast tick tap wrong");

    chk_slow_tick_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_ff && ctrl_ff[2:0] == 3'h7) |-> tap.tick_lvl == slow_s2_ff[1])
        else $error("slow tick tap wrong");

    chk_div_rate_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (!src_ff && !mode_s2_ff && ctrl_ff[6:5] == 2'h0) |-> tap.dvo_lvl == fast_s2_ff[13])
        else $error("divider output tap wrong");

    chk_pin_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_ff[`TBD_DVO_EN_BIT] ##1 !ctrl_ff[`TBD_DVO_EN_BIT] |-> divider_out_pin_n_o)
        else $error("pin active while disabled");

    chk_pin_follows_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_ff[`TBD_DVO_EN_BIT] |=> divider_out_pin_n_o == !$past(tap.dvo_lvl))
        else $error("pin not tracking tap");

    chk_combined_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_ff == tbd_pkg::TBD_BUS_ACK && wb_we_i && wb_sel_i[0] && wb_adr_i == `TBD_CTRL_OFS
         && wb_dat_i[7:0] == 8'h0a) |=> ctrl_ff == 8'h0a)
        else $error("combined rate and enable write lost");

    chk_low_speed_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_s2_ff && ctrl_ff[2:1] != 2'h0) |-> !tap.tick_ok)
        else $error("refused tick code let through");

    chk_low_speed_tap: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_s2_ff && ctrl_ff[2:0] == 3'h1) |-> tap.tick_lvl == slow_s2_ff[13])
        else $error("low speed tick tap wrong");

    chk_dvo_slow_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_s2_ff && ctrl_ff[6:5] == 2'h0) |-> tap.dvo_lvl == slow_s2_ff[5])
        else $error("low speed output tap wrong");
endmodule
`default_nettype wire

//--- hdl/tbd_map.svh
`ifndef TBD_MAP_SVH
`define TBD_MAP_SVH
// register byte offsets
`define TBD_CTRL_OFS        8'h00
`define TBD_CFG_OFS         8'h04
`define TBD_STAT_OFS        8'h08
// control register fields
`define TBD_DVO_EN_BIT      7
`define TBD_DVO_RATE_HI     6
`define TBD_DVO_RATE_LO     5
`define TBD_TB_EN_BIT       3
`define TBD_TICK_RATE_HI    2
`define TBD_TICK_RATE_LO    0
`define TBD_CTRL_RESET      8'h00
`define TBD_CTRL_WMASK      8'hef
// config register: divider source select
`define TBD_SRC_SEL_BIT     0
`define TBD_CFG_RESET       1'b0
// status register fields
`define TBD_STAT_TICK_BIT   0
`define TBD_STAT_DVO_BIT    1
`define TBD_STAT_SLOW_BIT   2
`define TBD_STAT_SRC_BIT    3
// divider chain widths (bit k carries clock / 2^(k+1))
`define TBD_FAST_W          24
`define TBD_SLOW_W          16
`endif

//--- hdl/tbd_pkg.sv
`default_nettype none
package tbd_pkg;
    typedef logic [2:0] tbd_tick_code_t;
    typedef logic [1:0] tbd_dvo_code_t;
    typedef enum logic [1:0] {
        TBD_BUS_IDLE,
        TBD_BUS_ACK
    } tbd_bus_state_t;
endpackage
`default_nettype wire

//--- hdl/tbd_tap_if.sv
`include "tbd_map.svh"
`default_nettype none
interface tbd_tap_if;
    logic [`TBD_FAST_W-1:0] fast_div;
    logic [`TBD_SLOW_W-1:0] slow_div;
    logic                   src_sel;
    logic                   slow_mode;
    tbd_pkg::tbd_tick_code_t tick_code;
    tbd_pkg::tbd_dvo_code_t  dvo_code;
    logic                   tick_lvl;
    logic                   tick_ok;
    logic                   dvo_lvl;
    modport top (output fast_div, slow_div, src_sel, slow_mode, tick_code, dvo_code,
                 input tick_lvl, tick_ok, dvo_lvl);
    modport sel (input fast_div, slow_div, src_sel, slow_mode, tick_code, dvo_code,
                 output tick_lvl, tick_ok, dvo_lvl);
endinterface
`default_nettype wire

//--- hdl/tbd_tap_sel.sv
`include "tbd_map.svh"
`default_nettype none
module tbd_tap_sel
(
    tbd_tap_if.sel tap
);
    // chain stage for each tick code, slow then fast source
    function automatic logic [4:0] tick_stage(input logic slow_src, input logic [2:0] code);
        logic [4:0] st;
        st = 5'h00;
        case (code)
            3'h0:    st = slow_src ? 5'd15 : 5'd23;
            3'h1:    st = slow_src ? 5'd13 : 5'd21;
            3'h2:    st = slow_src ? 5'd8  : 5'd16;
            3'h3:    st = slow_src ? 5'd6  : 5'd14;
            3'h4:    st = slow_src ? 5'd5  : 5'd13;
            3'h5:    st = slow_src ? 5'd4  : 5'd12;
            3'h6:    st = slow_src ? 5'd3  : 5'd11;
            default: st = slow_src ? 5'd1  : 5'd9;
        endcase
        return st;
    endfunction

    logic       use_slow;
    logic [4:0] t_stage;
    logic [4:0] d_stage;

    // low speed modes run off the slow chain regardless of the source bit
    always_comb
    begin
        use_slow = tap.src_sel | tap.slow_mode;
        t_stage  = tick_stage(use_slow, tap.tick_code);
        d_stage  = use_slow ? (5'd5 - {3'h0, tap.dvo_code}) : (5'd13 - {3'h0, tap.dvo_code});
        tap.tick_lvl = use_slow ? tap.slow_div[t_stage[3:0]] : tap.fast_div[t_stage];
        tap.tick_ok  = ~tap.slow_mode | ~tap.tick_code[2] & ~tap.tick_code[1];
        tap.dvo_lvl  = use_slow ? tap.slow_div[d_stage[3:0]] : tap.fast_div[d_stage];
    end
endmodule
`default_nettype wire

//--- bench/tbd_buzzer.sv
`default_nettype none
// piezo load: times each level of the active-low drive in clocks
module tbd_buzzer
(
    input  wire logic clk_i,
    input  wire logic drive_n_i,
    output int        low_len_o,
    output int        high_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   run = 0;
    logic last = 1'b1;
    // a level is recorded only once it ends, so stale lengths need a settle time
    always @(posedge clk_i)
    begin
        if (drive_n_i !== last)
        begin
            if (last === 1'b0)
                low_len_o <= run;
            else
                high_len_o <= run;
            run <= 1;
        end
        else
            run <= run + 1;
        last <= drive_n_i;
    end
endmodule
`default_nettype wire

//--- bench/time_base_and_divider_output_bench.sv
`include "tbd_map.svh"
`default_nettype none
module time_base_and_divider_output_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd;
    logic [23:0] cnt = 24'h0;
    logic        lsm = 1'b0;
    logic [2:0]  cur = 3'h0;
    logic [1:0]  dcur = 2'h0;
    wire  [31:0] rdat;
    wire         ack;
    wire         irq;
    wire         pin_n;
    int          low_len;
    int          high_len;
    int          k;
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          fbit[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
    int          sbit[8] = '{15, 13, 8, 6, 5, 4, 3, 1};
    always #10 clk_i = ~clk_i;
    // one chain feeds both taps; bit k toggles every 2^k clocks
    always @(posedge clk_i) cnt <= cnt + 24'h1;
    tbd_top u_tbd_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .fast_div_i(cnt), .slow_div_i(cnt[15:0]), .low_speed_mode_i(lsm),
        .timebase_irq_o(irq), .divider_out_pin_n_o(pin_n));
    tbd_buzzer u_tbd_buzzer (.clk_i(clk_i), .drive_n_i(pin_n), .low_len_o(low_len), .high_len_o(high_len));
    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic give_up;
        n_mismatch++;
        test_done();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic cycle: request held up to the edge that samples ack high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (ack === 1'b1)
                break;
        end
        if (i == 20)
            give_up();
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // gap between two pulses; a pulse longer than one clock shows as gap 1
    task automatic irq_gap(input int b);
        int i;
        int t0;
        t0 = -1;
        for (i = 0; i < 40000; i++)
        begin
            @(posedge clk_i);
            #1;
            if (irq === 1'b1 && t0 >= 0)
                break;
            if (irq === 1'b1)
                t0 = i;
        end
        if (i == 40000)
            give_up();
        check(32'(i - t0), 32'(2 << b));
    endtask
    task automatic no_irq;
        int i;
        int n;
        n = 0;
        for (i = 0; i < 2048; i++)
        begin
            @(posedge clk_i);
            #1;
            if (irq !== 1'b0)
                n++;
        end
        check(32'(n), 32'h0);
    endtask
    task automatic regs_case;
        check(32'(pin_n), 32'h1);
        wb(1'b0, `TBD_CTRL_OFS, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `TBD_CTRL_OFS, 32'hff);
        wb(1'b0, `TBD_CTRL_OFS, 32'h0);
        check(rd, 32'hef);
        // disable both with rates kept, only then clear the rates
        wb(1'b1, `TBD_CTRL_OFS, 32'h67);
        wb(1'b1, `TBD_CTRL_OFS, 32'h0);
        wb(1'b1, `TBD_CFG_OFS, 32'hff);
        wb(1'b0, `TBD_CFG_OFS, 32'h0);
        check(rd, 32'h1);
        wb(1'b1, `TBD_CFG_OFS, 32'h0);
        wb(1'b1, 8'h40, 32'hff);
        wb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, `TBD_CTRL_OFS, 32'h0);
        check(rd, 32'h0);
    endtask
    // negative b means the code is refused and no pulse may come
    task automatic tick_case(input logic s, input logic l, input logic [2:0] c, input int b);
        wb(1'b1, `TBD_CTRL_OFS, {29'h0, cur});
        wb(1'b1, `TBD_CFG_OFS, {31'h0, s});
        @(posedge clk_i);
        lsm <= l;
        wb(1'b1, `TBD_CTRL_OFS, {28'h0, 1'b1, c});
        cur = c;
        if (b < 0)
            no_irq();
        else
            irq_gap(b);
    endtask
    // run while a valid fast tap is selected, else the refusal hides the gate
    task automatic tick_off_case;
        wb(1'b1, `TBD_CTRL_OFS, {29'h0, cur});
        no_irq();
    endtask
    task automatic dvo_case(input logic s, input logic l, input logic [1:0] c, input int b);
        wb(1'b1, `TBD_CTRL_OFS, {25'h0, dcur, 5'h0});
        wb(1'b1, `TBD_CTRL_OFS, {25'h0, c, 5'h0});
        dcur = c;
        wb(1'b1, `TBD_CFG_OFS, {31'h0, s});
        lsm <= l;
        repeat (6) @(posedge clk_i);
        check(32'(pin_n), 32'h1);
        wb(1'b1, `TBD_CTRL_OFS, {24'h0, 1'b1, c, 5'h0});
        repeat (8 << b) @(posedge clk_i);
        check(32'(low_len), 32'(1 << b));
        check(32'(high_len), 32'(1 << b));
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        regs_case();
        for (k = 5; k < 8; k++)
            tick_case(1'b0, 1'b0, 3'(k), fbit[k]);
        tick_off_case();
        for (k = 2; k < 8; k++)
            tick_case(1'b1, 1'b0, 3'(k), sbit[k]);
        tick_case(1'b0, 1'b1, 3'h1, 13);
        tick_case(1'b0, 1'b1, 3'h2, -1);
        wb(1'b1, `TBD_CTRL_OFS, {29'h0, cur});
        for (k = 0; k < 4; k++)
            dvo_case(1'b1, 1'b0, 2'(k), 5 - k);
        dvo_case(1'b0, 1'b0, 2'h3, 10);
        dvo_case(1'b0, 1'b1, 2'h0, 5);
        test_done();
    end
endmodule
`default_nettype wire
